// ---- inc/ccm_defs.svh ----
// constants of the card controller misc configuration block:
// offsets, field positions, reset values and timing figures.
// assumes byte offsets in configuration space, data on a 32-bit word.
`ifndef CCM_DEFS_SVH
`define CCM_DEFS_SVH

// ==========================================
// register offsets (byte addresses)
`define CCM_SYSCTL_OFS    8'h80
`define CCM_DEBOUNCE_OFS  8'h84
`define CCM_GENCTL_OFS    8'h86

// ==========================================
// system control low bits
`define CCM_SC_PARITY_BIT 4
`define CCM_SC_SUPPLY_BIT 2
`define CCM_SC_KEEP_BIT   1
`define CCM_SC_WAKE_BIT   0
`define CCM_SC_ACT_BIT    13

// ==========================================
// general control bits
`define CCM_GC_QUERY_BIT  13
`define CCM_GC_LIMIT_BIT  12
`define CCM_GC_BASE_BIT   11
`define CCM_GC_PSW_BIT    10
`define CCM_GC_REV23_BIT  7
`define CCM_GC_FLASH_BIT  5
`define CCM_GC_SKTB_BIT   4
`define CCM_GC_FW_BIT     3
`define CCM_GC_ARB_LSB    0

// ==========================================
// reset values
`define CCM_DEBOUNCE_RST  8'h19
`define CCM_GENCTL_RST    16'h0080

// ==========================================
// timing
`define CCM_CLK_PERIOD_NS 100
`define CCM_DEB_STEP_NS   2000000

`endif

// ---- inc/ccm_pkg.sv ----
// types of the card controller misc configuration block.
// assumes nothing beyond a SystemVerilog compiler.
package ccm_pkg;

  // ==========================================
  // top-level arbitration modes
  typedef enum logic [1:0] {
    CCM_ARB_FIREWIRE = 2'h0,
    CCM_ARB_FLASH    = 2'h2,
    CCM_ARB_ROBIN    = 2'h3
  } ccm_arb_t;

  // ==========================================
  // debounce states, one-hot
  typedef enum logic [1:0] {
    CCM_DBN_STABLE = 2'h1,
    CCM_DBN_WAIT   = 2'h2
  } ccm_dbn_state_t;

endpackage : ccm_pkg

// ---- rtl/ccm_debounce.sv ----
// card-detect debouncer: holds a new level for a programmed number
// of step ticks before passing it on.
// assumes din is already synchronised to clk and tick is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module ccm_debounce (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic       din,
  input  wire logic [7:0] interval,
  output var  logic       dout_q
);

  ccm_pkg::ccm_dbn_state_t state_q;
  logic [7:0]              count_q;

  // ==========================================
  // state and counter
  // interval in step ticks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ccm_pkg::CCM_DBN_STABLE;
      count_q <= 8'h00;
      dout_q  <= 1'b0;
    end else begin
      case (state_q)
        ccm_pkg::CCM_DBN_STABLE: begin
          if (din != dout_q) begin
            if (interval == 8'h00) begin
              dout_q <= din;
            end else begin
              state_q <= ccm_pkg::CCM_DBN_WAIT;
              count_q <= 8'h00;
            end
          end
        end
        ccm_pkg::CCM_DBN_WAIT: begin
          if (din == dout_q) begin
            state_q <= ccm_pkg::CCM_DBN_STABLE; // bounce: give up
          end else if (tick) begin
            if (count_q + 8'h01 >= interval) begin
              dout_q  <= din;
              state_q <= ccm_pkg::CCM_DBN_STABLE;
            end
            count_q <= count_q + 8'h01;
          end
        end
        default: begin
          state_q <= ccm_pkg::CCM_DBN_STABLE;
        end
      endcase
    end
  end

  // ==========================================
  // checks
  // zero interval passes through
  a_zero_pass: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_q == ccm_pkg::CCM_DBN_STABLE && din != dout_q && interval == 8'h00) |=> (dout_q == $past(din)))
    else $error("zero interval did not pass level");

  a_hold_no_tick: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_q == ccm_pkg::CCM_DBN_WAIT && !tick) |=> $stable(dout_q))
    else $error("level accepted without a step tick");

endmodule : ccm_debounce
`default_nettype wire

// ---- rtl/ccm_regs.sv ----
// card controller misc configuration registers: system control low
// bits, card-detect debounce and general control, plus the wake pin mux.
// assumes single-cycle configuration accesses on sys_clk, byte enables
// over a 32-bit word, and a 10 MHz clock.
// Behaviour
// - parity enable bit 4 routes card data parity errors to system error.
// - reserved bits read zero; general control bits 15-14 do nothing.
// - legacy supply bit 2 reads 0 for 3.3 V, 1 for 5 V.
// - keep-alive bit holds both system and card bus clocks running.
// - output select 1 drives wake event onto the shared pin.
// - select 0 with ring enable 1 drives ring indicate onto the pin.
// - select 0 and ring enable 0 floats the shared pin.
// - control bits clear only on global reset.
// - debounce register sets card-detect debounce in 2 ms steps.
// - debounce register resets to 19h, fifty milliseconds, global reset only.
// - general control bit 13 shortens the card-type query time.
// - bit 12 forces I/O limit bit 0 for both card functions.
// - bit 11 forces I/O base bit 0 for both card functions.
// - bit 10 selects 1.8 V switch when 0, 12 V switch when 1.
// - general control bit 7 always reads 1.
// - bits 5, 4, 3 switch off flash, second socket, firewire functions.
// - arbitration field 00 firewire, 10 flash, 11 round robin.
// - socket activity flag sets on card access, clears on read.
`include "ccm_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ccm_regs #(
  parameter int DEB_STEP_CYC = `CCM_DEB_STEP_NS / `CCM_CLK_PERIOD_NS
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [2:0]  cfg_func,
  input  wire logic        cfg_rd,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output var  logic [31:0] cfg_rdata_q,
  output var  logic        cfg_rvalid_q,
  input  wire logic        legacy_supply_select,
  input  wire logic        cb_parity_err,
  input  wire logic        socket_access,
  input  wire logic        ring_indicate_enable,
  input  wire logic        ring_indicate_output,
  input  wire logic        pme_event,
  input  wire logic        media_card_detect_n,
  output var  logic        serr_req_q,
  output var  logic        pclk_keep_q,
  output var  logic        card_bus_clock_keep_q,
  output var  logic        shared_wake_ring_pin_o_q,
  output var  logic        shared_wake_ring_pin_oe_q,
  output logic             media_card_present_q,
  output var  logic        query_shorten_q,
  output var  logic        io_limit_bit0_q,
  output var  logic        io_base_bit0_q,
  output var  logic        power_switch_type_select_q,
  output var  logic        flash_function_off_q,
  output var  logic        second_socket_off_q,
  output var  logic        firewire_function_off_q,
  output var  logic [1:0]  top_arbitration_select_q
);
  // ==========================================
  // arbitration decode: unknown code falls back to firewire priority
  function automatic ccm_pkg::ccm_arb_t arb_decode(input logic [1:0] code);
    case (code)
      2'h2:    arb_decode = ccm_pkg::CCM_ARB_FLASH;
      2'h3:    arb_decode = ccm_pkg::CCM_ARB_ROBIN;
      default: arb_decode = ccm_pkg::CCM_ARB_FIREWIRE;
    endcase
  endfunction : arb_decode

  // word match on address bits 7:2, shared by write, read and check decode
  function automatic logic word_hit(input logic [7:0] addr, input logic [7:0] ofs);
    word_hit = (addr[7:2] == ofs[7:2]);
  endfunction : word_hit
  // ==========================================
  // reset synchroniser
  logic [1:0] rst_sync_q;
  logic       rst_n_q;
  // release reset through two flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_q = rst_sync_q[1];
  // ==========================================
  // register storage
  logic       cardbus_parity_report_en_q;
  logic       clock_keepalive_q;
  logic       wake_pin_output_select_q;
  logic       socket_activity_flag_q;
  logic [7:0] debounce_q;
  logic       gc_query_q;
  logic       gc_limit_q;
  logic       gc_base_q;
  logic       gc_psw_q;
  logic       gc_flash_q;
  logic       gc_sktb_q;
  logic       gc_fw_q;
  logic [1:0] gc_arb_q;
  logic       wr_sysctl;
  logic       wr_dbn;
  logic       rd_sysctl;
  // word decode of the two mapped words
  assign wr_sysctl = cfg_wr && word_hit(cfg_addr, `CCM_SYSCTL_OFS);
  assign wr_dbn    = cfg_wr && word_hit(cfg_addr, `CCM_DEBOUNCE_OFS);
  assign rd_sysctl = cfg_rd && word_hit(cfg_addr, `CCM_SYSCTL_OFS);
  // system control low bits
  // cleared by global reset only
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cardbus_parity_report_en_q <= 1'b0;
      clock_keepalive_q          <= 1'b0;
      wake_pin_output_select_q   <= 1'b0;
    // shared bits written from function 0 only
    end else if (wr_sysctl && cfg_be[0] && cfg_func == 3'h0) begin
      cardbus_parity_report_en_q <= cfg_wdata[`CCM_SC_PARITY_BIT];
      clock_keepalive_q          <= cfg_wdata[`CCM_SC_KEEP_BIT];
      wake_pin_output_select_q   <= cfg_wdata[`CCM_SC_WAKE_BIT];
    end
  end
  // socket activity flag
  // access sets, read clears, set wins
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      socket_activity_flag_q <= 1'b0;
    end else if (socket_access) begin
      socket_activity_flag_q <= 1'b1;
    end else if (rd_sysctl && cfg_be[1]) begin
      socket_activity_flag_q <= 1'b0;
    end
  end
  // debounce register
  // resets to 19h on global reset only
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      debounce_q <= `CCM_DEBOUNCE_RST;
    end else if (wr_dbn && cfg_be[0]) begin
      debounce_q <= cfg_wdata[7:0];
    end
  end
  // general control register, bytes 2 and 3 of the word
  // bits 15-14 are not stored and steer nothing
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gc_query_q <= 1'b0;
      gc_limit_q <= 1'b0;
      gc_base_q  <= 1'b0;
      gc_psw_q   <= 1'b0;
      gc_flash_q <= 1'b0;
      gc_sktb_q  <= 1'b0;
      gc_fw_q    <= 1'b0;
      gc_arb_q   <= 2'h0;
    end else begin
      if (wr_dbn && cfg_be[2]) begin
        gc_flash_q <= cfg_wdata[16 + `CCM_GC_FLASH_BIT];
        gc_sktb_q  <= cfg_wdata[16 + `CCM_GC_SKTB_BIT];
        gc_fw_q    <= cfg_wdata[16 + `CCM_GC_FW_BIT];
        gc_arb_q   <= cfg_wdata[17:16];
      end
      if (wr_dbn && cfg_be[3]) begin
        gc_query_q <= cfg_wdata[16 + `CCM_GC_QUERY_BIT];
        gc_limit_q <= cfg_wdata[16 + `CCM_GC_LIMIT_BIT];
        gc_base_q  <= cfg_wdata[16 + `CCM_GC_BASE_BIT];
        gc_psw_q   <= cfg_wdata[16 + `CCM_GC_PSW_BIT];
      end
    end
  end
  // ==========================================
  // read path
  logic [31:0] rd_word;
  logic [15:0] gc_word;
  // assemble the read word; unmapped words read zero
  always_comb begin
    gc_word = 16'h0000;
    gc_word[`CCM_GC_QUERY_BIT] = gc_query_q;
    gc_word[`CCM_GC_LIMIT_BIT] = gc_limit_q;
    gc_word[`CCM_GC_BASE_BIT]  = gc_base_q;
    gc_word[`CCM_GC_PSW_BIT]   = gc_psw_q;
    // revision conformance bit tied to 1
    gc_word[`CCM_GC_REV23_BIT] = 1'b1;
    gc_word[`CCM_GC_FLASH_BIT] = gc_flash_q;
    gc_word[`CCM_GC_SKTB_BIT]  = gc_sktb_q;
    gc_word[`CCM_GC_FW_BIT]    = gc_fw_q;
    gc_word[1:0]               = gc_arb_q;
    rd_word = 32'h0000_0000;
    if (word_hit(cfg_addr, `CCM_SYSCTL_OFS)) begin
      rd_word[`CCM_SC_PARITY_BIT] = cardbus_parity_report_en_q;
      // supply bit mirrors the selected supply
      rd_word[`CCM_SC_SUPPLY_BIT] = legacy_supply_select;
      rd_word[`CCM_SC_KEEP_BIT]   = clock_keepalive_q;
      rd_word[`CCM_SC_WAKE_BIT]   = wake_pin_output_select_q;
      rd_word[`CCM_SC_ACT_BIT]    = socket_activity_flag_q;
    end else if (word_hit(cfg_addr, `CCM_DEBOUNCE_OFS)) begin
      // reserved byte and bits stay zero
      rd_word = {gc_word, 8'h00, debounce_q};
    end
  end
  // registered read answer, one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_rdata_q  <= 32'h0000_0000;
      cfg_rvalid_q <= 1'b0;
    end else begin
      cfg_rvalid_q <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata_q <= rd_word;
      end
    end
  end
  // ==========================================
  // control outputs
  // parity error reported when enabled
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      serr_req_q <= 1'b0;
    end else begin
      serr_req_q <= cb_parity_err && cardbus_parity_report_en_q;
    end
  end
  // hold both clocks while keep-alive is set
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pclk_keep_q           <= 1'b0;
      card_bus_clock_keep_q <= 1'b0;
    end else begin
      pclk_keep_q           <= clock_keepalive_q;
      card_bus_clock_keep_q <= clock_keepalive_q;
    end
  end
  // shared wake / ring pin mux
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      shared_wake_ring_pin_o_q  <= 1'b0;
      shared_wake_ring_pin_oe_q <= 1'b0;
    end else if (wake_pin_output_select_q) begin
      shared_wake_ring_pin_o_q  <= pme_event;
      shared_wake_ring_pin_oe_q <= 1'b1;
    end else if (ring_indicate_enable) begin
      shared_wake_ring_pin_o_q  <= ring_indicate_output;
      shared_wake_ring_pin_oe_q <= 1'b1;
    end else begin
      shared_wake_ring_pin_o_q  <= 1'b0;
      shared_wake_ring_pin_oe_q <= 1'b0;
    end
  end
  // general control outputs
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      query_shorten_q            <= 1'b0;
      io_limit_bit0_q            <= 1'b0;
      io_base_bit0_q             <= 1'b0;
      power_switch_type_select_q <= 1'b0;
      flash_function_off_q       <= 1'b0;
      second_socket_off_q        <= 1'b0;
      firewire_function_off_q    <= 1'b0;
      top_arbitration_select_q   <= ccm_pkg::CCM_ARB_FIREWIRE;
    end else begin
      query_shorten_q            <= gc_query_q;
      io_limit_bit0_q            <= gc_limit_q;
      io_base_bit0_q             <= gc_base_q;
      power_switch_type_select_q <= gc_psw_q;
      flash_function_off_q       <= gc_flash_q;
      second_socket_off_q        <= gc_sktb_q;
      firewire_function_off_q    <= gc_fw_q;
      top_arbitration_select_q   <= arb_decode(gc_arb_q);
    end
  end
  // ==========================================
  // card-detect input: three flops, level taken when last two agree
  logic [2:0] cd_sync_q;
  logic       cd_level_q;
  logic [23:0] step_cnt_q;
  logic        step_tick_q;
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cd_sync_q  <= 3'h7;
      cd_level_q <= 1'b0;
    end else begin
      cd_sync_q <= {cd_sync_q[1:0], media_card_detect_n};
      if (cd_sync_q[1] == cd_sync_q[2]) begin
        cd_level_q <= !cd_sync_q[2]; // present when detect is low
      end
    end
  end
  // 2 ms step divider
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      step_cnt_q  <= 24'h00_0000;
      step_tick_q <= 1'b0;
    end else if (step_cnt_q == 24'(DEB_STEP_CYC - 1)) begin
      step_cnt_q  <= 24'h00_0000;
      step_tick_q <= 1'b1;
    end else begin
      step_cnt_q  <= step_cnt_q + 24'h00_0001;
      step_tick_q <= 1'b0;
    end
  end
  ccm_debounce u_debounce (
    .clk      (sys_clk),
    .rst_n    (rst_n_q),
    .tick     (step_tick_q),
    .din      (cd_level_q),
    .interval (debounce_q),
    .dout_q   (media_card_present_q)
  );
  // ==========================================
  // checks
  default clocking cb_main @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n_q);
  sequence s_act_read;
    rd_sysctl && cfg_be[1] && !socket_access;
  endsequence
  sequence s_pme_sel;
    wake_pin_output_select_q ##0 $stable(wake_pin_output_select_q);
  endsequence
  a_serr_report: assert property (
    serr_req_q == $past(cb_parity_err && cardbus_parity_report_en_q))
    else $error("system error report does not follow parity enable");
  a_rsvd_zero: assert property (
    (cfg_rd && word_hit(cfg_addr, `CCM_DEBOUNCE_OFS)) |=> (cfg_rdata_q[15:8] == 8'h00
      && cfg_rdata_q[31:30] == 2'h0 && cfg_rdata_q[25:24] == 2'h0 && !cfg_rdata_q[22] && !cfg_rdata_q[18]))
    else $error("reserved bits read nonzero");
  a_supply_read: assert property (
    rd_sysctl |=> cfg_rdata_q[`CCM_SC_SUPPLY_BIT] == $past(legacy_supply_select))
    else $error("supply bit mismatch");
  a_keep_clocks: assert property (
    clock_keepalive_q [*2] |-> (pclk_keep_q && card_bus_clock_keep_q))
    else $error("clocks not held by keep-alive");
  a_pme_route: assert property (
    s_pme_sel |=> (shared_wake_ring_pin_oe_q && shared_wake_ring_pin_o_q == $past(pme_event)))
    else $error("wake event not on shared pin");
  a_ri_route: assert property (
    (!wake_pin_output_select_q && ring_indicate_enable) |=>
      (shared_wake_ring_pin_oe_q && shared_wake_ring_pin_o_q == $past(ring_indicate_output)))
    else $error("ring indicate not on shared pin");
  a_pin_hiz: assert property (
    (!wake_pin_output_select_q && !ring_indicate_enable) |=> !shared_wake_ring_pin_oe_q)
    else $error("shared pin driven while released");
  a_rev23_one: assert property (
    (cfg_rd && word_hit(cfg_addr, `CCM_DEBOUNCE_OFS)) |=> cfg_rdata_q[16 + `CCM_GC_REV23_BIT])
    else $error("conformance bit read zero");
  a_func_off: assert property (
    $rose(gc_fw_q) |=> firewire_function_off_q ##0 $stable(gc_fw_q)[*1] or !gc_fw_q)
    else $error("firewire switch-off not applied");
  a_arb_map: assert property (
    (gc_arb_q == 2'h1) |=> top_arbitration_select_q == ccm_pkg::CCM_ARB_FIREWIRE)
    else $error("code 01 not mapped to firewire priority");
  a_act_set: assert property (
    socket_access |=> socket_activity_flag_q)
    else $error("activity not flagged");
  a_act_clear: assert property (
    s_act_read |=> !socket_activity_flag_q ##1 1'b1)
    else $error("activity flag not cleared by read");
endmodule : ccm_regs
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the misc configuration registers.
// assumes ccm_regs on a 10 MHz sys_clk with single-cycle config accesses.
`timescale 1ns/1ps
`default_nettype none
`include "ccm_defs.svh"
module tb_top;
  localparam int STEP = 10;
  logic        sys_clk, rstn, cfg_rd, cfg_wr, cfg_rvalid_q;
  logic [2:0]  cfg_func;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata_q;
  logic        supply, perr, sock, ren, ring, pme, cd_n, serr, pkeep, ckeep, pin_o, pin_oe, present;
  logic        qshort, iolim, iobase, psw, fl_off, sb_off, fw_off;
  logic [1:0]  arb;
  int          errors, checks, seed, c, lo, hi;
  logic [15:0] v;
  string       exp_name[$];
  logic [31:0] exp_val[$];

  ccm_regs #(.DEB_STEP_CYC(STEP)) DUT (.sys_clk(sys_clk), .rstn(rstn), .cfg_func(cfg_func), .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
    .cfg_rvalid_q(cfg_rvalid_q), .legacy_supply_select(supply), .cb_parity_err(perr), .socket_access(sock),
    .ring_indicate_enable(ren), .ring_indicate_output(ring), .pme_event(pme), .media_card_detect_n(cd_n),
    .serr_req_q(serr), .pclk_keep_q(pkeep), .card_bus_clock_keep_q(ckeep), .shared_wake_ring_pin_o_q(pin_o),
    .shared_wake_ring_pin_oe_q(pin_oe), .media_card_present_q(present), .query_shorten_q(qshort),
    .io_limit_bit0_q(iolim), .io_base_bit0_q(iobase), .power_switch_type_select_q(psw),
    .flash_function_off_q(fl_off), .second_socket_off_q(sb_off), .firewire_function_off_q(fw_off),
    .top_arbitration_select_q(arb));

  // ==========================================
  // clock, shared tasks
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle

  // one request held for exactly one sampling edge
  task automatic acc(input logic wr, input logic [2:0] fn, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    @(posedge sys_clk);
    cfg_wr    <= wr;
    cfg_rd    <= ~wr;
    cfg_func  <= fn;
    cfg_addr  <= a;
    cfg_be    <= be;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
  endtask : acc

  // note the expected word, then issue the read
  task automatic rd(input string name, input logic [7:0] a, input logic [3:0] be, input logic [31:0] e);
    exp_name.push_back(name);
    exp_val.push_back(e);
    acc(1'b0, 3'h0, a, be, 32'h0000_0000);
  endtask : rd

  task automatic global_reset;
    @(posedge sys_clk);
    rstn <= 1'b0;
    idle(2);
    rstn <= 1'b1;
    idle(4);
  endtask : global_reset

  // count system error pulses after one parity error pulse
  task automatic par_pulse(output int n);
    @(posedge sys_clk);
    perr <= 1'b1;
    @(posedge sys_clk);
    perr <= 1'b0;
    n = 0;
    repeat (4) begin
      @(posedge sys_clk);
      n += int'(serr === 1'b1);
    end
  endtask : par_pulse

  // time from card insertion to debounced presence
  task automatic deb(input logic [7:0] n);
    @(posedge sys_clk);
    cd_n <= 1'b1;
    idle(80);
    acc(1'b1, 3'h1, `CCM_DEBOUNCE_OFS, 4'h1, {24'h00_0000, n});
    @(posedge sys_clk);
    cd_n <= 1'b0;
    c = 0;
    while (present !== 1'b1 && c < 400) begin
      @(posedge sys_clk);
      c++;
    end
    lo = (n == 0) ? 0 : (n - 1) * STEP;
    hi = n * STEP + 8;
    check("debounce_time", 32'(c >= lo && c <= hi), 32'h0000_0001);
  endtask : deb

  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // ==========================================
  // read answer monitor
  always @(posedge sys_clk) begin
    if (cfg_rvalid_q === 1'b1) begin
      if (exp_name.size() == 0) check("unexpected_read", 32'h0000_0001, 32'h0000_0000);
      else check(exp_name.pop_front(), cfg_rdata_q, exp_val.pop_front());
    end
  end

  initial begin
    idle(20000);
    errors++;
    end_sim();
  end

  // ==========================================
  // main sequence
  initial begin
    seed = 32'ha234;
    {rstn, cfg_rd, cfg_wr, cfg_func, cfg_addr, cfg_be, cfg_wdata} = '0;
    {supply, perr, sock, ren, ring, pme} = '0;
    cd_n = 1'b1;
    idle(2);
    rstn <= 1'b1;
    idle(4);
    rd("reset_deb_gc", `CCM_DEBOUNCE_OFS, 4'hF, 32'h0080_0019);
    rd("reset_sysctl", `CCM_SYSCTL_OFS, 4'hF, 32'h0000_0000);
    acc(1'b1, 3'h0, `CCM_SYSCTL_OFS, 4'hF, 32'hFFFF_FFFF);
    acc(1'b1, 3'h1, `CCM_SYSCTL_OFS, 4'h1, 32'h0000_0000);
    rd("sysctl_func", `CCM_SYSCTL_OFS, 4'hF, 32'h0000_0013);
    check("keep_alive", {pkeep, ckeep}, 32'h0000_0003);
    acc(1'b1, 3'h0, 8'h88, 4'hF, 32'hFFFF_FFFF);
    rd("unmapped", 8'h88, 4'hF, 32'h0000_0000);
    $display("test sysctl done");
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 3'h0, `CCM_SYSCTL_OFS, 4'h1, 32'(i[1]));
      ren  <= i[0];
      pme  <= 1'($random(seed));
      ring <= 1'($random(seed));
      idle(3);
      check("pin_oe", pin_oe, 32'(i != 0));
      check("pin_o", pin_o, 32'(i[1] ? pme : (i[0] & ring)));
    end
    check("keep_off", {pkeep, ckeep}, 32'h0000_0000);
    $display("test pin mux done");
    acc(1'b1, 3'h0, `CCM_SYSCTL_OFS, 4'h1, 32'h0000_0010);
    par_pulse(c);
    check("serr_on", c, 32'h0000_0001);
    acc(1'b1, 3'h0, `CCM_SYSCTL_OFS, 4'h1, 32'h0000_0000);
    par_pulse(c);
    check("serr_off", c, 32'h0000_0000);
    $display("test parity done");
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 16'hFFFF : 16'($random(seed));
      acc(1'b1, 3'h2, `CCM_GENCTL_OFS, 4'hC, {v, 16'h0000});
      rd("genctl", `CCM_DEBOUNCE_OFS, 4'hF, {(v & 16'h3C3B) | 16'h0080, 16'h0019});
      idle(2);
      check("gc_outs", {qshort, iolim, iobase, psw, fl_off, sb_off, fw_off}, 32'({v[13:10], v[5:3]}));
    end
    for (int a = 0; a < 4; a++) begin
      acc(1'b1, 3'h0, `CCM_GENCTL_OFS, 4'hC, {16'(a), 16'h0000});
      idle(3);
      check("arbitration", arb, 32'((a == 1) ? 0 : a));
    end
    $display("test general control done");
    supply <= 1'b1;
    @(posedge sys_clk);
    sock <= 1'b1;
    @(posedge sys_clk);
    sock <= 1'b0;
    idle(2);
    rd("activity_set", `CCM_SYSCTL_OFS, 4'h3, 32'h0000_2004);
    rd("activity_clr", `CCM_SYSCTL_OFS, 4'h3, 32'h0000_0004);
    $display("test activity done");
    deb(8'h02);
    deb(8'h00);
    $display("test debounce done");
    acc(1'b1, 3'h0, `CCM_SYSCTL_OFS, 4'h1, 32'h0000_0013);
    acc(1'b1, 3'h0, `CCM_GENCTL_OFS, 4'hC, 32'h3C3B_0000);
    global_reset();
    rd("global_reset_deb_gc", `CCM_DEBOUNCE_OFS, 4'hF, 32'h0080_0019);
    rd("global_reset_sysctl", `CCM_SYSCTL_OFS, 4'hF, 32'h0000_0004);
    check("global_reset_outs", {pkeep, arb, qshort, fl_off}, 32'h0000_0000);
    idle(4);
    check("pending_reads", exp_name.size(), 32'h0000_0000);
    $display("test global reset done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
